/* File: core/iss_pkg.sv */
// iss_pkg: register map, field positions, reset values and carrier types
// for the i2c slave status flag block.
// assumes a 32-bit apb slave with a 12-bit byte address.
package iss_pkg;
   // register byte offsets
   localparam logic [11:0] ISS_OFF_STATUS = 12'h000;
   localparam logic [11:0] ISS_OFF_CTRL = 12'h004;
   localparam logic [11:0] ISS_OFF_IRQ_STAT = 12'h008;
   localparam logic [11:0] ISS_OFF_IRQ_MASK = 12'h00c;
   // flag width and bit positions, shared by status, irq status and mask
   localparam int ISS_FLAG_W = 8;
   localparam int ISS_BIT_RXQ = 3;
   localparam int ISS_BIT_OVF = 4;
   localparam int ISS_BIT_NACK = 5;
   localparam int ISS_BIT_BUSY = 6;
   localparam int ISS_BIT_GC = 7;
   // control bit positions
   localparam int ISS_CTL_FNACK = 0;
   localparam int ISS_CTL_GCCLR = 1;
   // reset values
   localparam logic ISS_FNACK_RST = 1'b0;
   localparam logic [7:0] ISS_MASK_RST = 8'h00;
   localparam logic ISS_FLAG_RST = 1'b0;
   // events from the slave bus engine, same clock, single-cycle pulses
   // except the fifo levels
   typedef struct packed {
      logic start_det;   // start or repeated start seen
      logic stop_det;    // stop seen
      logic addr_done;   // address byte received, pulse
      logic addr_match;  // address matched a slave id register
      logic addr_read;   // address byte asked for a read
      logic gencall_det; // general call of any type received
      logic rx_write;    // byte pushed into receive fifo, pulse
      logic rx_full;     // receive fifo full, level
      logic rx_empty;    // receive fifo empty, level
      logic tx_empty;    // transmit fifo empty, level
   } iss_evt_t;
   // the visible status flags
   typedef struct packed {
      logic gc;
      logic busy;
      logic nack;
      logic ovf;
      logic rxq;
   } iss_flags_t;
endpackage

/* File: core/iss_w1c.sv */
// iss_w1c: a vector of sticky bits, set by hardware, cleared by writing one.
// assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module iss_w1c #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] q
);
   logic [W-1:0] q_q; // sticky state
   logic [W-1:0] q_d; // next sticky state

   // set wins over a clear in the same cycle
   always_comb
   begin
      q_d = (q_q & ~clr) | set;
   end

   // register the sticky bits
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         q_q <= '0;
      end
      else
      begin
         q_q <= q_d;
      end
   end

   assign q = q_q;
endmodule // iss_w1c

/* File: core/iss_flags.sv */
// iss_flags: status flags of an i2c slave with an apb register port.
// assumes the bus engine delivers events on clk; the apb master holds
// its request until pready is seen high.
`timescale 1ns/1ps
// Contract
// - general call flag held until software clears
// - busy set on start condition
// - busy cleared on stop or address mismatch
// - nack flag set on address nack, else cleared
// - nack when tx empty or forced nack
// - overflow flag set on write into full fifo
// - general call flag set on any general call
// - receive request while fifo not empty, interrupts
module iss_flags
   import iss_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire iss_evt_t evt,
   output logic nack_req,
   output logic irq
);
   iss_flags_t flags_q; // visible flags
   iss_flags_t flags_d;
   logic force_nack_enable_q; // control: always nack matched addresses
   logic force_nack_enable_d;
   logic [7:0] mask_q; // interrupt mask
   logic [7:0] mask_d;
   logic [31:0] prdata_q; // read data
   logic [31:0] prdata_d;
   logic pready_q; // apb ready
   logic pready_d;
   logic pslverr_q; // apb error
   logic pslverr_d;
   logic nack_req_q; // tells the engine to nack the address
   logic nack_req_d;
   logic irq_q; // interrupt line
   logic irq_d;
   logic [7:0] irq_set; // sticky event sets
   logic [7:0] irq_clr; // software write-one clears
   logic [7:0] irq_stat; // sticky event bits
   logic acc; // access phase
   logic wr_fire; // write takes effect
   logic mapped; // address decodes to a register
   logic gencall_clear; // write of one to the clear control bit
   logic nack_cond; // this address is answered with a nack
   logic [7:0] status_word; // flags at their bit positions

   // apb decode
   always_comb
   begin
      acc = psel & penable;
      wr_fire = acc & pready_q & pwrite;
      mapped = (paddr == ISS_OFF_STATUS) || (paddr == ISS_OFF_CTRL) ||
               (paddr == ISS_OFF_IRQ_STAT) || (paddr == ISS_OFF_IRQ_MASK);
      gencall_clear = wr_fire && (paddr == ISS_OFF_CTRL) && pwdata[ISS_CTL_GCCLR];
      irq_clr = '0;
      if (wr_fire && (paddr == ISS_OFF_IRQ_STAT))
      begin
         irq_clr = pwdata[7:0];
      end
   end

   // nack decision for a matched address
   always_comb
   begin
      nack_cond = evt.addr_done && evt.addr_match &&
                  (force_nack_enable_q || (evt.addr_read && evt.tx_empty));
   end

   // flag next values
   always_comb
   begin
      flags_d = flags_q;
      // general call: set wins over the clear
      if (evt.gencall_det)
      begin
         flags_d.gc = 1'b1;
      end
      else if (gencall_clear)
      begin
         flags_d.gc = 1'b0;
      end
      // busy: a start sets it, stop or a mismatched address clears it
      if (evt.start_det)
      begin
         flags_d.busy = 1'b1;
      end
      else if (evt.stop_det || (evt.addr_done && !evt.addr_match))
      begin
         flags_d.busy = 1'b0;
      end
      // nack: set on a nacked address, cleared on any other address or start
      if (nack_cond)
      begin
         flags_d.nack = 1'b1;
      end
      else if (evt.addr_done || evt.start_det)
      begin
         flags_d.nack = 1'b0;
      end
      // overflow: set on a push into a full fifo, cleared by any good push
      if (evt.rx_write && evt.rx_full)
      begin
         flags_d.ovf = 1'b1;
      end
      else if (evt.rx_write)
      begin
         flags_d.ovf = 1'b0;
      end
      // receive request follows the fifo level
      flags_d.rxq = !evt.rx_empty;
   end

   // register the flags
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flags_q <= '{default: ISS_FLAG_RST};
      end
      else
      begin
         flags_q <= flags_d;
      end
   end

   // interrupt events in the status layout
   always_comb
   begin
      irq_set = '0;
      irq_set[ISS_BIT_GC] = evt.gencall_det;
      irq_set[ISS_BIT_NACK] = nack_cond;
      irq_set[ISS_BIT_OVF] = evt.rx_write & evt.rx_full;
      irq_set[ISS_BIT_RXQ] = !evt.rx_empty;
   end

   // sticky interrupt status
   iss_w1c #(.W(ISS_FLAG_W)) u_irq_stat (
      .clk(clk),
      .rst(rst),
      .set(irq_set),
      .clr(irq_clr),
      .q(irq_stat)
   );

   // status word, register writes, read data and handshake
   always_comb
   begin
      status_word = '0;
      status_word[ISS_BIT_GC] = flags_q.gc;
      status_word[ISS_BIT_BUSY] = flags_q.busy;
      status_word[ISS_BIT_NACK] = flags_q.nack;
      status_word[ISS_BIT_OVF] = flags_q.ovf;
      status_word[ISS_BIT_RXQ] = flags_q.rxq;
      force_nack_enable_d = force_nack_enable_q;
      mask_d = mask_q;
      if (wr_fire && (paddr == ISS_OFF_CTRL))
      begin
         force_nack_enable_d = pwdata[ISS_CTL_FNACK];
      end
      if (wr_fire && (paddr == ISS_OFF_IRQ_MASK))
      begin
         mask_d = pwdata[7:0];
      end
      pready_d = acc & !pready_q;
      pslverr_d = acc & !pready_q & !mapped;
      prdata_d = prdata_q;
      if (acc && !pready_q && !pwrite)
      begin
         case (paddr)
            ISS_OFF_STATUS: prdata_d = {24'h000000, status_word};
            ISS_OFF_CTRL: prdata_d = {31'h00000000, force_nack_enable_q};
            ISS_OFF_IRQ_STAT: prdata_d = {24'h000000, irq_stat};
            ISS_OFF_IRQ_MASK: prdata_d = {24'h000000, mask_q};
            default: prdata_d = 32'h00000000;
         endcase
      end
      nack_req_d = force_nack_enable_q | evt.tx_empty;
      irq_d = |(irq_stat & mask_q);
   end

   // register control, bus answer and outputs
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         force_nack_enable_q <= ISS_FNACK_RST;
         mask_q <= ISS_MASK_RST;
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         nack_req_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         force_nack_enable_q <= force_nack_enable_d;
         mask_q <= mask_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         nack_req_q <= nack_req_d;
         irq_q <= irq_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign nack_req = nack_req_q;
   assign irq = irq_q;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_GC_HOLD: assert property (
      flags_q.gc && !gencall_clear && !evt.gencall_det |=> flags_q.gc)
      else $error("general call flag dropped without a clear");
   AST_GC_CLEAR: assert property (
      gencall_clear && !evt.gencall_det |=> !flags_q.gc)
      else $error("general call clear did not clear the flag");
   AST_GC_SET: assert property (
      evt.gencall_det |=> flags_q.gc)
      else $error("general call not flagged");
   AST_BUSY_SET: assert property (
      evt.start_det |=> flags_q.busy)
      else $error("busy not set by start");
   AST_BUSY_CLR: assert property (
      !evt.start_det && (evt.stop_det || (evt.addr_done && !evt.addr_match))
      |=> !flags_q.busy)
      else $error("busy not cleared");
   AST_NACK_SET: assert property (
      evt.addr_done && evt.addr_match && evt.addr_read && evt.tx_empty
      |=> flags_q.nack)
      else $error("nack flag not set for empty tx fifo");
   AST_NACK_CAUSE: assert property (
      evt.addr_done && !(evt.addr_match && (force_nack_enable_q ||
      (evt.addr_read && evt.tx_empty))) |=> !flags_q.nack)
      else $error("nack flag set without a cause");
   AST_OVF: assert property (
      evt.rx_write |=> flags_q.ovf == $past(evt.rx_full))
      else $error("overflow flag does not follow the push");
   AST_RXQ_IRQ: assert property (
      !evt.rx_empty && mask_q[ISS_BIT_RXQ] && !wr_fire ##1 !wr_fire |-> ##1 irq_q)
      else $error("receive request did not interrupt");
   AST_STATUS_RD: assert property (
      acc && !pready_q && !pwrite && (paddr == ISS_OFF_STATUS)
      |=> pready_q && (prdata_q[7:3] == $past(flags_q)))
      else $error("status read does not show the flags");
   AST_PREADY_PULSE: assert property (
      pready_q |=> !pready_q)
      else $error("pready held for more than one cycle");
endmodule // iss_flags

/* File: sim/iss_master_model.sv */
// iss_master_model: behavioural stand-in for the slave bus engine while an
// external i2c master talks to it; turns bus happenings into evt pulses.
// assumes the flag block samples evt on the rising edge of clk.
`timescale 1ns/1ps
module iss_master_model
   import iss_pkg::*;
(
   input wire logic clk,
   output iss_evt_t evt
);
   iss_evt_t lvl; // fifo levels held between events
   // idle bus: fifos empty, nothing pending
   initial
   begin
      lvl = '0;
      lvl.rx_empty = 1'b1;
      lvl.tx_empty = 1'b1;
      evt = lvl;
   end
   // one-cycle event on top of the held levels
   task send(input iss_evt_t p);
      @(posedge clk);
      evt <= p | lvl;
      @(posedge clk);
      evt <= lvl;
   endtask
   // new fifo levels, driven right after the edge the caller stands on
   task fifo(input logic full, input logic empty, input logic txe);
      lvl.rx_full = full;
      lvl.rx_empty = empty;
      lvl.tx_empty = txe;
      evt <= lvl;
   endtask
   task start(); send(10'h200); endtask // start or repeated start
   task stop(); send(10'h100); endtask // stop condition
   task addr(input logic m, input logic r); send({2'b00, 1'b1, m, r, 5'h00}); endtask
   task gcall(); send(10'h010); endtask // general call received
   task push(); send(10'h008); endtask // byte into receive fifo
endmodule // iss_master_model

/* File: sim/testbench.sv */
// testbench: self-checking bench for iss_flags, apb master plus bus model.
// assumes pready answers within a few cycles of the access phase.
`timescale 1ns/1ps
module testbench
   import iss_pkg::*;
;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, nack_req, irq;
   logic [11:0] paddr; // apb byte address
   logic [31:0] pwdata, prdata; // apb data
   iss_evt_t evt; // events from the bus model
   int n_fail, checks, cyc;
   iss_flags u_iss_flags (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .evt(evt), .nack_req(nack_req), .irq(irq));
   iss_master_model u_master (.clk(clk), .evt(evt));
   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_fail++;
         wrap_up();
      end
   end
   task wrap_up();
      if (n_fail == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // compare and count
   task chk(input logic [31:0] g, input logic [31:0] x);
      checks++;
      if (g !== x)
      begin
         n_fail++;
         $display("ERROR %0t got %h exp %h", $time, g, x);
      end
   endtask
   // one apb transfer: setup, access, wait for pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // no local limit: only the hang guard ends a wait for pready
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] x, input logic xe = 1'b0);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // busy across start, stop, mismatch and repeated start
   task t_busy();
      u_master.start();
      rd(ISS_OFF_STATUS, 32'h40);
      u_master.addr(1'b0, 1'b0);
      rd(ISS_OFF_STATUS, 32'h00);
      u_master.start();
      u_master.stop();
      rd(ISS_OFF_STATUS, 32'h00);
      u_master.start();
      u_master.addr(1'b1, 1'b0);
      u_master.start();
      rd(ISS_OFF_STATUS, 32'h40);
      u_master.addr(1'b0, 1'b0);
      rd(ISS_OFF_STATUS, 32'h00);
   endtask
   // nack on empty tx fifo and on forced nack, cleared otherwise
   task t_nack();
      u_master.start();
      u_master.addr(1'b1, 1'b1);
      rd(ISS_OFF_STATUS, 32'h60);
      chk({31'h0, nack_req}, 32'h1);
      u_master.start();
      rd(ISS_OFF_STATUS, 32'h40);
      u_master.fifo(1'b0, 1'b1, 1'b0);
      u_master.addr(1'b1, 1'b1);
      rd(ISS_OFF_STATUS, 32'h40);
      chk({31'h0, nack_req}, 32'h0);
      wr(ISS_OFF_CTRL, 32'h1);
      rd(ISS_OFF_CTRL, 32'h1);
      u_master.addr(1'b1, 1'b0);
      rd(ISS_OFF_STATUS, 32'h60);
      chk({31'h0, nack_req}, 32'h1);
      wr(ISS_OFF_CTRL, 32'h0);
      u_master.start();
      u_master.stop();
      rd(ISS_OFF_STATUS, 32'h00);
   endtask
   // overflow only on a push into a full fifo; request while not empty
   task t_ovf();
      u_master.fifo(1'b1, 1'b0, 1'b1);
      u_master.push();
      rd(ISS_OFF_STATUS, 32'h18);
      u_master.fifo(1'b0, 1'b0, 1'b1);
      u_master.push();
      rd(ISS_OFF_STATUS, 32'h08);
      // unmask the receive request while the fifo still holds data
      wr(ISS_OFF_IRQ_MASK, 32'h08);
      rd(ISS_OFF_IRQ_MASK, 32'h08);
      chk({31'h0, irq}, 32'h1);
      u_master.fifo(1'b0, 1'b1, 1'b1);
      rd(ISS_OFF_STATUS, 32'h00);
      // sticky events: nack, overflow and receive request
      rd(ISS_OFF_IRQ_STAT, 32'h38);
      wr(ISS_OFF_IRQ_STAT, 32'hff);
      rd(ISS_OFF_IRQ_STAT, 32'h00);
      chk({31'h0, irq}, 32'h0);
   endtask
   // general call sticky until cleared, with and without the interrupt
   task t_gc();
      wr(ISS_OFF_IRQ_MASK, 32'h80);
      u_master.gcall();
      rd(ISS_OFF_STATUS, 32'h80);
      rd(ISS_OFF_STATUS, 32'h80);
      chk({31'h0, irq}, 32'h1);
      wr(ISS_OFF_IRQ_STAT, 32'h80);
      rd(ISS_OFF_IRQ_STAT, 32'h00);
      chk({31'h0, irq}, 32'h0);
      wr(ISS_OFF_CTRL, 32'h2);
      rd(ISS_OFF_STATUS, 32'h00);
      rd(ISS_OFF_CTRL, 32'h0);
      wr(ISS_OFF_IRQ_MASK, 32'h00);
      u_master.gcall();
      rd(ISS_OFF_IRQ_STAT, 32'h80);
      chk({31'h0, irq}, 32'h0);
      wr(ISS_OFF_CTRL, 32'h2);
   endtask
   // main sequence
   initial
   begin
      n_fail = 0;
      checks = 0;
      cyc = 0;
      rst = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(ISS_OFF_STATUS, 32'h00);
      wr(ISS_OFF_STATUS, 32'hff);
      rd(ISS_OFF_STATUS, 32'h00);
      rd(12'h010, 32'h0, 1'b1);
      t_busy();
      t_nack();
      t_ovf();
      t_gc();
      wrap_up();
   end
endmodule // testbench
